// >>> rtl/pin_router_pkg.sv
// How it works
// - only digital signals pass through the selection network.
// - analog functions stay on their own pins, never routed here.
// - input routing and output routing use separate registers and logic.
// - each peripheral input has a selector choosing its source pin.
// - each pin has an output selector choosing its driving source.
// - receive selector code 0x17 feeds port C bit 7 to serial receiver.
// - code 0x09 on port C bit 6 drives first serial transmit.
// - several peripheral inputs may share one pin, each sees its level.
// - port level read returns the pin level regardless of selections.
// - each input accepts only its permitted ports, per package variant.
// - input selectors load their listed default codes at reset.
// - output code 0x00 drives the pin from its output latch.
// - direction control owns the driver unless a peripheral overrides.
package pin_router_pkg;
  localparam int NUM_IN   = 38;
  localparam int NUM_PINS = 32;
  localparam int SEL_W    = 8;
  localparam int OUT_W    = 5;
  localparam logic [11:0] IN_SEL_BASE   = 12'h000;
  localparam logic [11:0] OUT_SEL_BASE  = 12'h100;
  localparam logic [11:0] PORT_LVL_ADDR = 12'h180;
  localparam int CODE_PORT_LSB = 3;
  localparam int CODE_TOP_LSB  = 5;
  localparam logic [OUT_W-1:0] OUT_CODE_LATCH = 5'h00;
  localparam logic [OUT_W-1:0] OUT_SER1_TX    = 5'h09;
  localparam logic [OUT_W-1:0] OUT_SEL_RST    = 5'h00;
  localparam logic [SEL_W-1:0] IN_CODE_RC7    = 8'h17;
  localparam int PIN_RC6 = 22;
  localparam int PIN_RC7 = 23;

  typedef enum logic [5:0] {
    ext_irq0_pin_select, ext_irq1_pin_select, ext_irq2_pin_select,
    timer0_clock_pin_select, timer1_clock_pin_select,
    timer1_gate_pin_select, timer3_clock_pin_select,
    timer3_gate_pin_select, timer5_clock_pin_select,
    timer5_gate_pin_select, timer2_clock_pin_select,
    timer4_clock_pin_select, timer6_clock_pin_select,
    adc_trigger_pin_select, capture1_pin_select, capture2_pin_select,
    waveform_gen_in_pin_select, modulator_carrier_low_pin_select,
    modulator_carrier_high_pin_select, modulator_source_pin_select,
    serial1_receive_pin_select, serial1_clock_pin_select,
    serial2_receive_pin_select, serial2_clock_pin_select,
    sync_port1_clock_pin_select, sync_port1_data_pin_select,
    sync_port1_select_pin_select, sync_port2_clock_pin_select,
    sync_port2_data_pin_select, sync_port2_select_pin_select,
    logic_cell_in0_pin_select, logic_cell_in1_pin_select,
    logic_cell_in2_pin_select, logic_cell_in3_pin_select,
    logic_cell_in4_pin_select, logic_cell_in5_pin_select,
    logic_cell_in6_pin_select, logic_cell_in7_pin_select
  } in_sel_idx_t;

  localparam logic [SEL_W-1:0] IN_SEL_RST [NUM_IN] = '{
    8'h08, 8'h09, 8'h0a, 8'h04, 8'h10, 8'h0d, 8'h10, 8'h10,
    8'h12, 8'h0c, 8'h13, 8'h15, 8'h0f, 8'h0c, 8'h12, 8'h11,
    8'h08, 8'h03, 8'h04, 8'h05, 8'h17, 8'h16, 8'h0f, 8'h0e,
    8'h13, 8'h14, 8'h05, 8'h09, 8'h0a, 8'h08, 8'h00, 8'h01,
    8'h0e, 8'h0f, 8'h00, 8'h01, 8'h0e, 8'h0f};

  // permitted ports, bit n set means port n (a=0 .. d=3)
  localparam logic [3:0] MASK_28 [NUM_IN] = '{
    4'h3, 4'h3, 4'h3, 4'h3, 4'h5, 4'h6, 4'h6, 4'h5,
    4'h5, 4'h6, 4'h5, 4'h6, 4'h6, 4'h6, 4'h6, 4'h6,
    4'h6, 4'h5, 4'h5, 4'h5, 4'h6, 4'h6, 4'h6, 4'h6,
    4'h6, 4'h6, 4'h5, 4'h6, 4'h6, 4'h6, 4'h5, 4'h5,
    4'h6, 4'h6, 4'h5, 4'h5, 4'h6, 4'h6};
  localparam logic [3:0] MASK_40 [NUM_IN] = '{
    4'h3, 4'h3, 4'h3, 4'h3, 4'h5, 4'h6, 4'h6, 4'h5,
    4'h5, 4'ha, 4'h5, 4'h6, 4'ha, 4'ha, 4'h6, 4'h6,
    4'ha, 4'h9, 4'h9, 4'h9, 4'h6, 4'h6, 4'ha, 4'ha,
    4'h6, 4'h6, 4'h9, 4'ha, 4'ha, 4'ha, 4'h5, 4'h5,
    4'ha, 4'ha, 4'h5, 4'h5, 4'ha, 4'ha};
endpackage : pin_router_pkg

// >>> rtl/peripheral_input_pin_router.sv
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/100ps
module peripheral_input_pin_router
  import pin_router_pkg::*;
#(
  parameter bit PKG_40PIN = 1'b1
) (
  input  wire logic                core_clk,
  input  wire logic                reset_n,
  input  wire logic                clk_en,
  input  wire logic [11:0]         paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [NUM_PINS-1:0] pin_in,
  input  wire logic [NUM_PINS-1:0] pin_analog_select_bit,
  input  wire logic [NUM_PINS-1:0] lat_val,
  input  wire logic [NUM_PINS-1:0] dir_in,
  input  wire logic [NUM_PINS-1:0] per_out,
  input  wire logic [NUM_PINS-1:0] per_oe_ovr,
  input  wire logic [NUM_PINS-1:0] per_oe,
  output logic      [NUM_PINS-1:0] pin_out,
  output logic      [NUM_PINS-1:0] pin_oe,
  output logic      [NUM_IN-1:0]   per_in
);

  logic [SEL_W-1:0] in_sel_r  [NUM_IN];
  logic [OUT_W-1:0] out_sel_r [NUM_PINS];
  logic [31:0]      prdata_r;
  logic [31:0]      rd_nxt;
  logic             pready_r;
  logic             pslverr_r;
  logic             err_nxt;
  logic             access;
  logic             wr_take;
  logic             aligned;
  logic             in_hit;
  logic             out_hit;
  logic             lvl_hit;
  logic [5:0]       in_idx;
  logic [4:0]       out_idx;

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  assign in_idx  = paddr[7:2];
  assign out_idx = paddr[6:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign in_hit  = aligned &&
                   (paddr[11:8] == IN_SEL_BASE[11:8]) &&
                   (in_idx < 6'(NUM_IN));
  assign out_hit = aligned &&
                   (paddr[11:7] == OUT_SEL_BASE[11:7]);
  assign lvl_hit = (paddr == PORT_LVL_ADDR);

  // one wait state: the answer is registered, so decode stays off
  // the pready path
  assign access  = psel && penable && !pready_r;
  assign wr_take = psel && penable && pready_r && pwrite && pstrb[0];

  always_comb begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    if (in_hit) begin
      rd_nxt = {24'h00_0000, in_sel_r[in_idx]};
    end else if (out_hit) begin
      rd_nxt = {27'h000_0000, out_sel_r[out_idx]};
    end else if (lvl_hit) begin
      // raw pin level, independent of any selection
      rd_nxt = pin_in;
    end else begin
      err_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready_r  <= access;
      pslverr_r <= access && err_nxt;
      if (access) begin
        prdata_r <= rd_nxt;
      end
    end
  end

  // peripheral input selectors, kept apart from output selectors
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_IN; i++) begin
        in_sel_r[i] <= IN_SEL_RST[i];
      end
    end else if (clk_en && wr_take && in_hit) begin
      in_sel_r[in_idx] <= pwdata[SEL_W-1:0];
    end
  end

  // pin output selectors; upper bits are not stored and read as zero
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int p = 0; p < NUM_PINS; p++) begin
        out_sel_r[p] <= OUT_SEL_RST;
      end
    end else if (clk_en && wr_take && out_hit) begin
      out_sel_r[out_idx] <= pwdata[OUT_W-1:0];
    end
  end

  for (genvar i = 0; i < NUM_IN; i++) begin : g_in
    logic [3:0] ok;
    logic [4:0] pin;
    logic       hit;
    logic       q_r;
    assign ok  = PKG_40PIN ? MASK_40[i] : MASK_28[i];
    // bits 4:3 pick the port, 2:0 the bit: together the pin index
    assign pin = in_sel_r[i][4:0];
    // codes outside the permitted ports feed a constant low
    assign hit = (in_sel_r[i][SEL_W-1:CODE_TOP_LSB] == 3'b000) &&
                 ok[pin[4:CODE_PORT_LSB]];
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        q_r <= 1'b0;
      end else if (clk_en) begin
        // any number of inputs may read the same pin
        // digital buffer only: analog-selected pins read low
        q_r <= hit && pin_in[pin] && !pin_analog_select_bit[pin];
      end
    end
    assign per_in[i] = q_r;
  end

  // analog signals have their own fixed paths outside this block
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_out
    logic [OUT_W-1:0] code;
    logic             drv;
    logic             oe;
    logic             out_r;
    logic             oe_r;
    assign code = out_sel_r[p];
    // code 0 takes the port latch; others index the peripheral outputs
    assign drv  = (code == OUT_CODE_LATCH) ? lat_val[p]
                                           : per_out[code];
    // direction control rules unless the source takes the driver
    assign oe   = (code != OUT_CODE_LATCH && per_oe_ovr[code]) ?
                  per_oe[code] : !dir_in[p];
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        out_r <= 1'b0;
        oe_r  <= 1'b0;
      end else if (clk_en) begin
        out_r <= drv;
        oe_r  <= oe;
      end
    end
    assign pin_out[p] = out_r;
    assign pin_oe[p]  = oe_r;
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_lvl_setup;
    clk_en && psel && !penable && !pwrite && (paddr == PORT_LVL_ADDR);
  endsequence

  sequence s_lvl_access;
    clk_en && psel && penable && !pready_r &&
    (paddr == PORT_LVL_ADDR);
  endsequence

  property p_port_read;
    s_lvl_setup ##1 s_lvl_access |=>
      pready && !pslverr && (prdata == $past(pin_in));
  endproperty
  a_port_read: assert property (p_port_read)
    else $error("port level read does not return pin level");

  property p_rx_rc7;
    clk_en && (in_sel_r[serial1_receive_pin_select] == IN_CODE_RC7) &&
    !pin_analog_select_bit[PIN_RC7]
    |=> per_in[serial1_receive_pin_select] == $past(pin_in[PIN_RC7]);
  endproperty
  a_rx_rc7: assert property (p_rx_rc7)
    else $error("serial receive input not fed from port c bit 7");

  property p_tx_rc6;
    clk_en && (out_sel_r[PIN_RC6] == OUT_SER1_TX)
    |=> pin_out[PIN_RC6] == $past(per_out[OUT_SER1_TX]);
  endproperty
  a_tx_rc6: assert property (p_tx_rc6)
    else $error("port c bit 6 not driven by serial transmit");

  property p_latch;
    clk_en && (out_sel_r[0] == OUT_CODE_LATCH)
    |=> pin_out[0] == $past(lat_val[0]);
  endproperty
  a_latch: assert property (p_latch)
    else $error("latch code does not drive pin from latch");

  property p_dir;
    clk_en && (out_sel_r[0] == OUT_CODE_LATCH)
    |=> pin_oe[0] == !$past(dir_in[0]);
  endproperty
  a_dir: assert property (p_dir)
    else $error("pin enable not following direction control");

  property p_share;
    clk_en && (in_sel_r[ext_irq0_pin_select] ==
               in_sel_r[waveform_gen_in_pin_select]) &&
    (in_sel_r[ext_irq0_pin_select] == IN_SEL_RST[ext_irq0_pin_select])
    |=> per_in[ext_irq0_pin_select] ==
        per_in[waveform_gen_in_pin_select];
  endproperty
  a_share: assert property (p_share)
    else $error("inputs sharing one pin see different levels");

  property p_bad_port;
    clk_en && (in_sel_r[ext_irq0_pin_select][4:3] == 2'd2)
    |=> !per_in[ext_irq0_pin_select];
  endproperty
  a_bad_port: assert property (p_bad_port)
    else $error("forbidden port reached a peripheral input");

  property p_analog;
    clk_en && pin_analog_select_bit[PIN_RC7] &&
    (in_sel_r[serial1_receive_pin_select] == IN_CODE_RC7)
    |=> !per_in[serial1_receive_pin_select];
  endproperty
  a_analog: assert property (p_analog)
    else $error("analog-selected pin passed to a digital input");

  property p_reset_vals;
    $rose(reset_n) |->
      (in_sel_r[ext_irq0_pin_select] == 8'h08) &&
      (in_sel_r[serial1_receive_pin_select] == 8'h17);
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("selector reset value wrong");

  property p_indep;
    clk_en && wr_take && in_hit |=> $stable(out_sel_r[PIN_RC6]);
  endproperty
  a_indep: assert property (p_indep)
    else $error("input selector write changed an output selector");

  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready held longer than one cycle");

  property p_freeze;
    !clk_en |=> $stable(pready) && $stable(pslverr) && $stable(prdata) &&
                $stable(per_in) && $stable(pin_out) && $stable(pin_oe);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while clock enable low");

  property p_wr_in;
    clk_en && wr_take && in_hit &&
    (in_idx == 6'(serial1_receive_pin_select))
    |=> in_sel_r[serial1_receive_pin_select] == $past(pwdata[SEL_W-1:0]);
  endproperty
  a_wr_in: assert property (p_wr_in)
    else $error("input selector write did not land");

  property p_wr_out;
    clk_en && wr_take && out_hit && (out_idx == 5'(PIN_RC6))
    |=> out_sel_r[PIN_RC6] == $past(pwdata[OUT_W-1:0]);
  endproperty
  a_wr_out: assert property (p_wr_out)
    else $error("output selector write did not land");

  property p_indep_out;
    clk_en && wr_take && out_hit
    |=> $stable(in_sel_r[serial1_receive_pin_select]);
  endproperty
  a_indep_out: assert property (p_indep_out)
    else $error("output selector write changed an input selector");

  sequence s_setup;
    clk_en && psel && !penable;
  endsequence

  sequence s_first_access;
    clk_en && psel && penable;
  endsequence

  property p_wait;
    s_setup ##1 s_first_access |-> !pready;
  endproperty
  a_wait: assert property (p_wait)
    else $error("answer came without the wait state");

  sequence s_bad_access;
    clk_en && psel && penable && !pready_r &&
    !in_hit && !out_hit && !lvl_hit;
  endsequence

  property p_err_resp;
    s_bad_access |=> pready && pslverr;
  endproperty
  a_err_resp: assert property (p_err_resp)
    else $error("unmapped access not answered with error");

  property p_no_strb;
    clk_en && psel && penable && pready_r && pwrite && !pstrb[0]
    |=> $stable(in_sel_r[ext_irq0_pin_select]);
  endproperty
  a_no_strb: assert property (p_no_strb)
    else $error("write without low byte strobe changed a selector");

  property p_oe_ovr;
    clk_en && (out_sel_r[PIN_RC6] == OUT_SER1_TX) && per_oe_ovr[OUT_SER1_TX]
    |=> pin_oe[PIN_RC6] == $past(per_oe[OUT_SER1_TX]);
  endproperty
  a_oe_ovr: assert property (p_oe_ovr)
    else $error("overriding source did not take the driver enable");

  property p_oe_dir;
    clk_en && (out_sel_r[PIN_RC6] == OUT_SER1_TX) && !per_oe_ovr[OUT_SER1_TX]
    |=> pin_oe[PIN_RC6] == !$past(dir_in[PIN_RC6]);
  endproperty
  a_oe_dir: assert property (p_oe_dir)
    else $error("driver enable not from direction control");

  property p_top_bits;
    clk_en &&
    (in_sel_r[timer1_gate_pin_select][SEL_W-1:CODE_TOP_LSB] != 3'b000)
    |=> !per_in[timer1_gate_pin_select];
  endproperty
  a_top_bits: assert property (p_top_bits)
    else $error("code above port range reached a peripheral input");

  sequence s_rx_sel_read;
    clk_en && psel && penable && !pready_r && !pwrite && in_hit &&
    (in_idx == 6'(serial1_receive_pin_select));
  endsequence

  property p_rd_sel;
    s_rx_sel_read |=>
      prdata == {24'h00_0000, $past(in_sel_r[serial1_receive_pin_select])};
  endproperty
  a_rd_sel: assert property (p_rd_sel)
    else $error("selector read does not return stored code");

  property p_reset_out;
    $rose(reset_n) |->
      (per_in == '0) && (pin_out == '0) && (pin_oe == '0);
  endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("routed outputs not quiet at reset release");

endmodule : peripheral_input_pin_router

// >>> bench/pin_side_model.sv
`timescale 1ns/100ps
module pin_side_model
  import pin_router_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                shuffle,
  input  wire logic [NUM_PINS-1:0] analog_select_bit_req,
  output logic      [NUM_PINS-1:0] pin_in,
  output logic      [NUM_PINS-1:0] pin_analog_select_bit,
  output logic      [NUM_PINS-1:0] lat_val,
  output logic      [NUM_PINS-1:0] dir_in,
  output logic      [NUM_PINS-1:0] per_out,
  output logic      [NUM_PINS-1:0] per_oe_ovr,
  output logic      [NUM_PINS-1:0] per_oe
);
  integer seed   = 29;
  logic   primed = 1'b0;
  // analog buffers stay on only where a scenario asks for it
  assign pin_analog_select_bit = analog_select_bit_req;
  // one process owns the pins: quiet levels first, random on request
  always @(posedge core_clk) begin
    primed <= 1'b1;
    if (shuffle) begin
      pin_in     <= $random(seed);
      lat_val    <= $random(seed);
      dir_in     <= $random(seed);
      per_out    <= $random(seed);
      per_oe_ovr <= $random(seed);
      per_oe     <= $random(seed);
    end else if (!primed) begin
      {pin_in, lat_val, dir_in, per_out, per_oe_ovr, per_oe} <= '0;
    end
  end
endmodule : pin_side_model

// >>> bench/testbench.sv
`timescale 1ns/100ps
module testbench;
  import pin_router_pkg::*;
  typedef struct packed {logic rd; logic err; logic [31:0] d;} note_t;
  logic                core_clk  = 1'b0;
  logic                reset_n   = 1'b0;
  logic                psel      = 1'b0;
  logic                penable   = 1'b0;
  logic                pwrite    = 1'b0;
  logic                shuffle   = 1'b0;
  logic                clk_en    = 1'b1;
  logic                stall     = 1'b0;
  logic [11:0]         paddr     = '0;
  logic [31:0]         pwdata    = '0;
  logic [3:0]          pstrb     = 4'hf;
  logic [NUM_PINS-1:0] analog_select_bit_req = '0;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic [NUM_PINS-1:0] pin_in, pin_analog_select_bit, lat_val, dir_in, per_out;
  logic [NUM_PINS-1:0] per_oe_ovr, per_oe, pin_out, pin_oe;
  logic [NUM_IN-1:0]   per_in;
  logic [7:0]          icode [NUM_IN];
  logic [4:0]          ocode [NUM_PINS];
  note_t               notes [$];
  int                  n_errors = 0;
  int                  n_checks = 0;

  peripheral_input_pin_router #(.PKG_40PIN(1'b1)) i_dut (
    .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_analog_select_bit(pin_analog_select_bit),
    .lat_val(lat_val), .dir_in(dir_in), .per_out(per_out),
    .per_oe_ovr(per_oe_ovr), .per_oe(per_oe), .pin_out(pin_out),
    .pin_oe(pin_oe), .per_in(per_in));
  pin_side_model i_pins (
    .core_clk(core_clk), .shuffle(shuffle), .analog_select_bit_req(analog_select_bit_req),
    .pin_in(pin_in), .pin_analog_select_bit(pin_analog_select_bit), .lat_val(lat_val),
    .dir_in(dir_in), .per_out(per_out), .per_oe_ovr(per_oe_ovr),
    .per_oe(per_oe));

  initial forever #2 core_clk = ~core_clk;

  task finish_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  // one idle cycle between transfers keeps each signal to one write a step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           input logic [3:0] s, input logic [31:0] ed, input logic ee);
    int n;
    @(posedge core_clk);
    notes.push_back({~w, ee, ed});
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    // frozen enable must hold the access phase without an answer
    if (stall) begin
      clk_en <= 1'b0;
      repeat (3) @(posedge core_clk);
      clk_en <= 1'b1;
    end
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      finish_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  always @(posedge core_clk) begin
    note_t n;
    if (psel && penable && pready === 1'b1) begin
      n = notes.pop_front();
      chk({31'h0, pslverr}, {31'h0, n.err});
      if (n.rd) chk(prdata, n.d);
    end
  end

  task routes;
    logic [4:0] c;
    shuffle <= 1'b1;
    @(posedge core_clk);
    shuffle <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    for (int i = 0; i < NUM_IN; i++) begin
      c = icode[i][4:0];
      chk({31'h0, per_in[i]}, {31'h0, icode[i][7:5] == 3'h0 &&
          MASK_40[i][c[4:3]] && pin_in[c] && !pin_analog_select_bit[c]});
    end
    for (int p = 0; p < NUM_PINS; p++) begin
      c = ocode[p];
      chk({30'h0, pin_out[p], pin_oe[p]}, {30'h0,
          c == 5'h00 ? lat_val[p] : per_out[c],
          (c != 5'h00 && per_oe_ovr[c]) ? per_oe[c] : !dir_in[p]});
    end
  endtask : routes

  initial begin
    for (int i = 0; i < NUM_IN; i++) icode[i] = IN_SEL_RST[i];
    for (int p = 0; p < NUM_PINS; p++) ocode[p] = 5'h00;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < NUM_IN; i++)
      apb(1'b0, 12'(4*i), '0, 4'hf, {24'h0, IN_SEL_RST[i]}, 1'b0);
    apb(1'b0, 12'h17c, '0, 4'hf, 32'h0, 1'b0);
    routes();
    $display("test reset done");
    for (int i = 0; i < NUM_IN; i++) begin
      icode[i] = 8'h12;
      apb(1'b1, 12'(4*i), 32'h12, 4'hf, '0, 1'b0);
    end
    routes();
    analog_select_bit_req <= 32'h0004_0000;
    routes();
    analog_select_bit_req <= '0;
    $display("test shared pin done");
    for (int i = 0; i < NUM_IN; i++) begin
      icode[i] = (i == 5) ? 8'h32 : (i == 20) ? IN_CODE_RC7 : 8'(i*7%32);
      apb(1'b1, 12'(4*i), {24'h0, icode[i]}, 4'hf, '0, 1'b0);
    end
    routes();
    analog_select_bit_req <= 32'h0080_0000;
    routes();
    analog_select_bit_req <= '0;
    for (int i = 0; i < NUM_IN; i++)
      apb(1'b0, 12'(4*i), '0, 4'hf, {24'h0, icode[i]}, 1'b0);
    $display("test codes done");
    for (int p = 0; p < NUM_PINS; p++) begin
      ocode[p] = (p == PIN_RC6) ? OUT_SER1_TX : (p % 3 == 0) ? 5'h0 : 5'(p);
      apb(1'b1, 12'h100 + 12'(4*p), {27'h0, ocode[p]}, 4'hf, '0, 1'b0);
    end
    routes();
    $display("test outputs done");
    apb(1'b0, 12'h200, '0, 4'hf, 32'h0, 1'b1);
    apb(1'b1, 12'h002, 32'h5, 4'hf, '0, 1'b1);
    apb(1'b1, PORT_LVL_ADDR, '1, 4'hf, '0, 1'b0);
    stall = 1'b1;
    apb(1'b0, PORT_LVL_ADDR, '0, 4'hf, pin_in, 1'b0);
    stall = 1'b0;
    apb(1'b1, 12'h000, 32'h1f, 4'h0, '0, 1'b0);
    apb(1'b0, 12'h000, '0, 4'hf, {24'h0, icode[0]}, 1'b0);
    $display("test refusals done");
    finish_test();
  end

  initial begin
    #100000;
    n_errors++;
    finish_test();
  end
endmodule : testbench
